// ===== rtl/pbsi_pkg.sv
// shared constants and types for the pipelined burst sram interface
package pbsi_pkg;
   //------------------------------------------------------------
   // widths and organisation
   //------------------------------------------------------------
   localparam int ADDR_W     = 18;
   localparam int DATA_W     = 16;
   localparam int LANE_W     = 9;
   localparam int LANES      = 2;
   localparam int WORD_W     = 18;
   localparam int MEM_DEPTH  = 262144;
   localparam int FIFO_DEPTH = 4;
   //------------------------------------------------------------
   // pending-operation record layout
   //------------------------------------------------------------
   localparam int OP_W        = 22;
   localparam int OP_ACT      = 21;
   localparam int OP_WR       = 20;
   localparam int OP_ADDR_LSB = 2;
   localparam int OP_BW_LSB   = 0;
   //------------------------------------------------------------
   // reset values
   //------------------------------------------------------------
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [1:0]        BEAT_FIRST = 2'h0;
   localparam logic [1:0]        BEAT_STEP  = 2'h1;
   localparam logic [OP_W-1:0]   OP_NONE    = 22'h000000;
   //------------------------------------------------------------
   // burst direction state
   //------------------------------------------------------------
   typedef enum logic [1:0] {
      PBSI_IDLE  = 2'b00,
      PBSI_READ  = 2'b01,
      PBSI_WRITE = 2'b10
   } pbsi_burst_t;
endpackage

// ===== rtl/pbsi_fifo.sv
// small flip-flop fifo for pending operation records
`timescale 1ns/1ps
module pbsi_fifo
   import pbsi_pkg::*;
#(
   parameter int WIDTH = OP_W,
   parameter int DEPTH = FIFO_DEPTH
)(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
   localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

   logic [WIDTH-1:0] slot [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   logic             push;
   logic             pop;

   //------------------------------------------------------------
   // handshake terms
   //------------------------------------------------------------
   // full and empty come straight from the occupancy count
   assign in_ready  = (count != FULL_COUNT);
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = slot[rd_ptr];

   // storage written by index, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         slot[wr_ptr] <= in_data;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : PW'(wr_ptr + 1'b1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : PW'(rd_ptr + 1'b1);
         end
      end
   end

   // occupancy; simultaneous push and pop leaves it unchanged
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= '0;
      end else if (push && !pop) begin
         count <= (PW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         count <= (PW+1)'(count - 1'b1);
      end
   end
endmodule

// ===== rtl/pbsi_sram.sv
// pipelined burst sram core: command decode, burst counter, array and data pins
//
// Contract
// - selected only when all three selects true
// - deselect with load low ends the burst
// - data bus floats two cycles after deselect
// - advance ignores address, bumps burst counter
// - burst direction fixed at load time
// - advance after read is next burst read
// - suspended edge changes no register except data_oe_n, which reloads from drive
// - data outputs float after first clock edge
// - lane one strobe writes low byte, parity
// - lane two strobe writes high byte, parity
// - any strobe mix; reads ignore strobes
// - lane three and four strobes unused
// - interleaved order: start xor beat count
// - linear order: start plus beat count
// - counter wraps after four beats, keeps going
// - load read data driven at cycle n+2
// - four beats follow on consecutive cycles
// - write data captured two enabled cycles later
// - output enable high floats pins asynchronously
// - sleep gates clock, keeps contents
`timescale 1ns/1ps
module pbsi_sram
   import pbsi_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              clock_enable_n,
   input  wire logic              chip_select_low_a_n,
   input  wire logic              chip_select_low_b_n,
   input  wire logic              chip_select_high,
   input  wire logic              advance_or_load,
   input  wire logic              read_not_write,
   input  wire logic [ADDR_W-1:0] word_address,
   input  wire logic              byte_write_strobe_lane_one_n,
   input  wire logic              byte_write_strobe_lane_two_n,
   input  wire logic              burst_order_select,
   input  wire logic              sleep_request,
   input  wire logic              output_enable_n,
   input  wire logic [DATA_W-1:0] data_in,
   input  wire logic              parity_bit_lane_one_in,
   input  wire logic              parity_bit_lane_two_in,
   output logic      [DATA_W-1:0] data_out,
   output logic                   parity_bit_lane_one_out,
   output logic                   parity_bit_lane_two_out,
   output logic                   data_oe_n
);
   //------------------------------------------------------------
   // declarations
   //------------------------------------------------------------
   logic [WORD_W-1:0] mem [MEM_DEPTH];
   pbsi_burst_t       burst_state;
   logic [ADDR_W-3:0] burst_base;
   logic [1:0]        burst_start;
   logic [1:0]        burst_count;
   logic [1:0]        next_count;
   logic              en;
   logic              edge_ok;
   logic              selected;
   logic              do_load;
   logic              do_desel;
   logic              do_adv;
   logic [OP_W-1:0]   next_op;
   logic              fifo_in_ready;
   logic              head_valid;
   logic [OP_W-1:0]   head_op;
   logic [OP_W-1:0]   stage_op;
   logic [WORD_W-1:0] wr_word;
   logic [WORD_W-1:0] old_word;
   logic [WORD_W-1:0] merged_word;
   logic [WORD_W-1:0] rd_word;
   logic              drive;
   logic              next_drive;
   logic [1:0]        stage_bw;
   logic [ADDR_W-1:0] stage_addr;
   logic [ADDR_W-1:0] head_addr;
   logic              stage_write;

   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   // low address bits of a beat; shared by the read and write advance paths
   function automatic logic [1:0] beat_low(input logic [1:0] start,
                                           input logic [1:0] cnt,
                                           input logic       interleave);
      if (interleave) begin
         return start ^ cnt;
      end
      return 2'(start + cnt);
   endfunction

   //------------------------------------------------------------
   // command decode
   //------------------------------------------------------------
   // sleep behaves like a held clock enable so nothing moves
   // suspend and sleep freeze every register except data_oe_n, which reloads from drive
   assign en       = !clock_enable_n && !sleep_request;
   // fifo back-pressure stalls the whole core like a suspend
   assign edge_ok  = en && fifo_in_ready;
   assign selected = !chip_select_low_a_n && !chip_select_low_b_n && chip_select_high;
   assign do_load  = selected && !advance_or_load;
   assign do_desel = !selected && !advance_or_load;
   assign do_adv   = advance_or_load;
   // two-bit counter wraps naturally after beat four
   assign next_count = 2'(burst_count + BEAT_STEP);

   // record of what this edge asks for; a read launches one edge later, a write lands two edges later
   always_comb begin
      next_op = OP_NONE;
      if (do_load) begin
         next_op[OP_ACT] = 1'b1;
         next_op[OP_WR]  = !read_not_write;
         next_op[OP_ADDR_LSB +: ADDR_W] = word_address;
         next_op[OP_BW_LSB +: 2] = {byte_write_strobe_lane_two_n,
                                    byte_write_strobe_lane_one_n};
      end else if (do_adv) begin
         case (burst_state)
            // advance after read is a burst read
            PBSI_READ: begin
               next_op[OP_ACT] = 1'b1;
               next_op[OP_ADDR_LSB +: ADDR_W] =
                  {burst_base, beat_low(burst_start, next_count, burst_order_select)};
            end
            // direction comes from the load, not the pin
            PBSI_WRITE: begin
               next_op[OP_ACT] = 1'b1;
               next_op[OP_WR]  = 1'b1;
               next_op[OP_ADDR_LSB +: ADDR_W] =
                  {burst_base, beat_low(burst_start, next_count, burst_order_select)};
               next_op[OP_BW_LSB +: 2] = {byte_write_strobe_lane_two_n,
                                          byte_write_strobe_lane_one_n};
            end
            // advance with no burst is an idle cycle
            default: begin
               next_op = OP_NONE;
            end
         endcase
      end
   end

   //------------------------------------------------------------
   // burst tracking
   //------------------------------------------------------------
   // deselect ends the burst; pending ops still run out
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         burst_state <= PBSI_IDLE;
      end else if (edge_ok) begin
         if (do_load) begin
            burst_state <= read_not_write ? PBSI_READ : PBSI_WRITE;
         end else if (do_desel) begin
            burst_state <= PBSI_IDLE;
         end
      end
   end

   // base and start captured on load, counter stepped on advance
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         burst_base  <= '0;
         burst_start <= BEAT_FIRST;
         burst_count <= BEAT_FIRST;
      end else if (edge_ok) begin
         if (do_load) begin
            burst_base  <= word_address[ADDR_W-1:2];
            burst_start <= word_address[1:0];
            burst_count <= BEAT_FIRST;
         end else if (do_adv && burst_state != PBSI_IDLE) begin
            burst_count <= next_count;
         end
      end
   end

   //------------------------------------------------------------
   // pending operation pipeline
   //------------------------------------------------------------
   // every enabled edge pushes one record; the next one pops it
   pbsi_fifo #(
      .WIDTH (OP_W),
      .DEPTH (FIFO_DEPTH)
   ) u_pending (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (en),
      .in_ready  (fifo_in_ready),
      .in_data   (next_op),
      .out_valid (head_valid),
      .out_ready (edge_ok),
      .out_data  (head_op)
   );

   // second stage holds a write until its data edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stage_op <= OP_NONE;
      end else if (edge_ok) begin
         stage_op <= head_valid ? head_op : OP_NONE;
      end
   end

   assign stage_addr  = stage_op[OP_ADDR_LSB +: ADDR_W];
   assign stage_bw    = stage_op[OP_BW_LSB +: 2];
   assign stage_write = stage_op[OP_ACT] && stage_op[OP_WR];
   assign head_addr   = head_op[OP_ADDR_LSB +: ADDR_W];

   //------------------------------------------------------------
   // array write with byte lanes
   //------------------------------------------------------------
   assign wr_word  = {parity_bit_lane_two_in, data_in[15:8],
                      parity_bit_lane_one_in, data_in[7:0]};
   assign old_word = mem[stage_addr];

   // low strobe writes its lane only
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      assign merged_word[l*LANE_W +: LANE_W] =
         stage_bw[l] ? old_word[l*LANE_W +: LANE_W] : wr_word[l*LANE_W +: LANE_W];
   end

   // write data sampled two enabled edges after command
   always_ff @(posedge clk) begin
      if (edge_ok && stage_write) begin
         mem[stage_addr] <= merged_word;
      end
   end

   //------------------------------------------------------------
   // read path and pin drive
   //------------------------------------------------------------
   // forward a write landing on the same edge as a read
   assign rd_word = (stage_write && stage_addr == head_addr) ? merged_word : mem[head_addr];
   // writes, idles and deselects float the bus
   assign next_drive = head_valid && head_op[OP_ACT] && !head_op[OP_WR];

   // read word launched one edge after command
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         drive                   <= 1'b0;
         data_out                <= DATA_RESET;
         parity_bit_lane_one_out <= 1'b0;
         parity_bit_lane_two_out <= 1'b0;
      end else if (edge_ok) begin
         drive <= next_drive;
         if (next_drive) begin
            data_out                <= {rd_word[16:9], rd_word[7:0]};
            parity_bit_lane_one_out <= rd_word[8];
            parity_bit_lane_two_out <= rd_word[17];
         end
      end
   end

   // enable pin presets the flop at once; drive returns next edge
   // pins float after reset and while enable is high
   always_ff @(posedge clk or posedge reset or posedge output_enable_n) begin
      if (reset) begin
         data_oe_n <= 1'b1;
      end else if (output_enable_n) begin
         data_oe_n <= 1'b1;
      end else begin
         data_oe_n <= edge_ok ? !next_drive : !drive;
      end
   end

   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // a selected load captures address and direction
   load_capture_a: assert property (edge_ok && do_load |=>
      burst_base == $past(word_address[ADDR_W-1:2]) && burst_count == BEAT_FIRST &&
      burst_state == ($past(read_not_write) ? PBSI_READ : PBSI_WRITE))
      else $error("load did not capture address or direction");
   desel_ends_burst_a: assert property (edge_ok && do_desel |=> burst_state == PBSI_IDLE)
      else $error("deselect did not end the burst");
   desel_float_a: assert property (edge_ok && do_desel ##1 edge_ok |=> data_oe_n)
      else $error("bus driven two cycles after deselect");
   adv_count_a: assert property (edge_ok && do_adv && burst_state != PBSI_IDLE |=>
      burst_count == 2'($past(burst_count) + BEAT_STEP))
      else $error("burst counter did not advance");
   adv_direction_a: assert property (edge_ok && do_adv |=> $stable(burst_state))
      else $error("burst direction changed on advance");
   suspend_hold_a: assert property (!edge_ok |=> $stable(data_out) && $stable(burst_count)
      && $stable(stage_op))
      else $error("state moved on a suspended edge");
   interleave_beat_a: assert property (edge_ok && do_load && burst_order_select
      ##1 edge_ok && do_adv ##1 edge_ok && do_adv |=>
      stage_addr[1:0] == (burst_start ^ 2'h1))
      else $error("interleaved beat address wrong");
   linear_beat_a: assert property (edge_ok && do_load && !burst_order_select
      ##1 edge_ok && do_adv ##1 edge_ok && do_adv |=>
      stage_addr[1:0] == 2'(burst_start + 2'h1))
      else $error("linear beat address wrong");
   wrap_four_a: assert property ((edge_ok && do_adv && burst_state != PBSI_IDLE)[*4] |=>
      burst_count == $past(burst_count, 4))
      else $error("counter did not wrap after four beats");
   read_latency_a: assert property (edge_ok && do_load && read_not_write
      ##1 (edge_ok && !output_enable_n) |=> output_enable_n || !data_oe_n)
      else $error("read data not driven at n+2");
   oe_float_a: assert property (output_enable_n |-> data_oe_n)
      else $error("pins driven while output enable high");
   idle_float_a: assert property (edge_ok && do_adv && burst_state == PBSI_IDLE
      ##1 edge_ok |=> data_oe_n)
      else $error("idle cycle drove the bus");

   burst_read_c: cover property (edge_ok && do_load && read_not_write
      ##1 (edge_ok && do_adv)[*3]);
   burst_write_c: cover property (edge_ok && do_load && !read_not_write
      ##1 (edge_ok && do_adv)[*3]);
   lane_one_only_c: cover property (edge_ok && stage_write && stage_bw == 2'b10);
   read_after_write_c: cover property (edge_ok && do_load && !read_not_write
      ##1 edge_ok && do_load && read_not_write);
endmodule

// ===== sim/pbsi_host_model.sv
// host-side data bus model for the pipelined burst sram bench
`timescale 1ns/1ps
module pbsi_host_model
   import pbsi_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              data_oe_n,
   input  wire logic              wr_en,
   input  wire logic [WORD_W-1:0] wr_word,
   output logic      [DATA_W-1:0] data_in,
   output logic                   parity_bit_lane_one_in,
   output logic                   parity_bit_lane_two_in
);
   logic [WORD_W-1:0] idle_word = 18'h2a5a5;
   logic [WORD_W-1:0] bus;

   // released bus toggles every cycle so stale data never looks valid
   always @(posedge clk) begin
      idle_word <= ~idle_word;
   end

   assign bus = (wr_en && data_oe_n) ? wr_word : idle_word;

   // lane one low nine, lane two high nine
   assign data_in                = {bus[16:9], bus[7:0]};
   assign parity_bit_lane_one_in = bus[8];
   assign parity_bit_lane_two_in = bus[17];
endmodule

// ===== sim/tb_pipelined_burst_sram_interface.sv
// self-checking bench: behavioural sram model against the core, random command mix
`timescale 1ns/1ps
module tb_pipelined_burst_sram_interface;
   import pbsi_pkg::*;
   //------------------------------------------------------------
   // signals and model state
   //------------------------------------------------------------
   typedef struct packed {
      logic [1:0]        kind;
      logic [ADDR_W-1:0] addr;
      logic [1:0]        bw;
      logic [WORD_W-1:0] word;
   } pbsi_op_t;
   logic              clk = 1'b0;
   logic              reset = 1'b1;
   logic              clock_enable_n = 1'b0;
   logic              chip_select_low_a_n = 1'b1;
   logic              chip_select_low_b_n = 1'b1;
   logic              chip_select_high = 1'b0;
   logic              advance_or_load = 1'b0;
   logic              read_not_write = 1'b1;
   logic [ADDR_W-1:0] word_address = 18'h00000;
   logic              byte_write_strobe_lane_one_n = 1'b1;
   logic              byte_write_strobe_lane_two_n = 1'b1;
   logic              burst_order_select = 1'b0;
   logic              sleep_request = 1'b0;
   logic              output_enable_n = 1'b0;
   logic [DATA_W-1:0] data_in, data_out;
   logic              parity_bit_lane_one_in, parity_bit_lane_two_in;
   logic              parity_bit_lane_one_out, parity_bit_lane_two_out, data_oe_n;
   logic              wr_en = 1'b0;
   logic [WORD_W-1:0] wr_word = 18'h00000;
   logic [WORD_W-1:0] mem [16];
   pbsi_op_t          s1, s2;
   logic [1:0]        b_dir, b_k;
   logic [ADDR_W-1:0] b_base;
   logic              exp_oe_n;
   logic [WORD_W-1:0] exp_word;
   int                miscompares = 0;
   int                n_tests = 0;
   int                seed = 32'hc10f621a;

   pbsi_sram dut (
      .clk, .reset, .clock_enable_n, .chip_select_low_a_n, .chip_select_low_b_n,
      .chip_select_high, .advance_or_load, .read_not_write, .word_address,
      .byte_write_strobe_lane_one_n, .byte_write_strobe_lane_two_n, .burst_order_select,
      .sleep_request, .output_enable_n, .data_in, .parity_bit_lane_one_in,
      .parity_bit_lane_two_in, .data_out, .parity_bit_lane_one_out,
      .parity_bit_lane_two_out, .data_oe_n
   );
   pbsi_host_model host (
      .clk, .data_oe_n, .wr_en, .wr_word, .data_in, .parity_bit_lane_one_in,
      .parity_bit_lane_two_in
   );

   // 10 MHz clock
   initial begin
      forever #50 clk = ~clk;
   end

   //------------------------------------------------------------
   // tasks
   //------------------------------------------------------------
   task automatic check(input string nm, input logic [17:0] exp, input logic [17:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask

   task report_and_stop;
      if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // memory is not reset, so the model keeps mem across resets
   task automatic do_reset(input logic order);
      reset <= 1'b1;
      advance_or_load <= 1'b0;
      chip_select_low_a_n <= 1'b1;
      {output_enable_n, sleep_request, clock_enable_n} <= 3'b000;
      wr_en <= 1'b0;
      burst_order_select <= order;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      s1 = '0;
      s2 = '0;
      b_dir = 2'h0;
      b_k = 2'h0;
      b_base = '0;
      exp_oe_n = 1'b1;
      exp_word = '0;
   endtask

   // sel is {high, low_b_n, low_a_n}; sus is {output enable, sleep, clock enable}
   task automatic step(input logic [2:0] sel, input logic adv, input logic rnw,
                       input logic [3:0] ad, input logic [1:0] bw, input logic [2:0] sus);
      pbsi_op_t op;
      @(posedge clk);
      if (!clock_enable_n && !sleep_request) begin
         if (s2.kind == 2'h2 && !s2.bw[0]) mem[s2.addr[3:0]][8:0] = s2.word[8:0];
         if (s2.kind == 2'h2 && !s2.bw[1]) mem[s2.addr[3:0]][17:9] = s2.word[17:9];
         if (!advance_or_load) begin
            b_dir = (!chip_select_low_a_n && !chip_select_low_b_n && chip_select_high)
                    ? (read_not_write ? 2'h1 : 2'h2) : 2'h0;
            b_base = word_address;
            b_k = 2'h0;
         end else begin
            b_k = b_k + 2'h1;
         end
         op.kind = b_dir;
         op.addr = {b_base[ADDR_W-1:2],
                    burst_order_select ? b_base[1:0] ^ b_k : b_base[1:0] + b_k};
         op.bw = {byte_write_strobe_lane_two_n, byte_write_strobe_lane_one_n};
         op.word = WORD_W'($random(seed));
         s2 = s1;
         s1 = op;
         exp_oe_n = (s2.kind != 2'h1);
         exp_word = mem[s2.addr[3:0]];
      end
      {chip_select_high, chip_select_low_b_n, chip_select_low_a_n} <= sel;
      advance_or_load <= adv;
      read_not_write <= rnw;
      word_address <= {14'h3fff, ad};
      {byte_write_strobe_lane_two_n, byte_write_strobe_lane_one_n} <= bw;
      {output_enable_n, sleep_request, clock_enable_n} <= sus;
      // host data for the write two edges back
      wr_en <= (s2.kind == 2'h2);
      wr_word <= s2.word;
      #1;
      check("data_oe_n", {17'h0, exp_oe_n | sus[2]}, {17'h0, data_oe_n});
      if (!exp_oe_n && !sus[2]) check("read_word", exp_word,
         {parity_bit_lane_two_out, data_out[15:8], parity_bit_lane_one_out, data_out[7:0]});
      if (wr_en && !data_oe_n) check("bus_free", 18'h0, 18'h1);
   endtask

   // random mix: bursts, deselects, suspends, sleep, every strobe pair
   task automatic phase;
      logic [31:0] r;
      repeat (300) begin
         r = $random(seed);
         step(r[1:0] == 2'h0 ? r[4:2] : 3'b100, r[5], r[6], r[10:7], r[12:11],
              {1'b0, r[15:13] == 3'h0, r[18:16] == 3'h0});
      end
   endtask

   //------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------
   initial begin
      do_reset(1'b0);
      // back-to-back full writes give every test word a known value
      for (int i = 0; i < 16; i++) step(3'b100, 1'b0, 1'b0, 4'(i), 2'b00, 3'b000);
      phase();
      // output enable high floats a due read at once
      step(3'b100, 1'b0, 1'b1, 4'h5, 2'b11, 3'b000);
      step(3'b000, 1'b0, 1'b1, 4'h0, 2'b11, 3'b000);
      step(3'b000, 1'b0, 1'b1, 4'h0, 2'b11, 3'b100);
      repeat (2) step(3'b000, 1'b0, 1'b1, 4'h0, 2'b11, 3'b000);
      do_reset(1'b1);
      phase();
      report_and_stop();
   end

   // watchdog, about three times the expected run
   initial begin
      #(2000 * 100);
      miscompares++;
      report_and_stop();
   end
endmodule
